// ### rtl/fail_output_and_alt_gpio.sv
// Purpose: Failure collection, three fail outputs and alternate pin use
// Assumes: All inputs synchronous to sys_clk_i; mode given by mode logic
// Notes:   Pin outputs are registered; open-drain and switch pins use oe
//
// Summary of operation
// R1 - Three open-drain active-low fail pins driven from one failure logic.
// R2 - Second-stage thermal shutdown or supply short activates fail pins.
// R3 - Watchdog failure activates on first in configs 1/2, second in 3/4.
// R4 - Supply overvoltage activates fail pins only when its enable is set.
// R5 - Four consecutive supply undervoltage events activate fail pins.
// R6 - Activation requests fail-safe entry; watchdog case set by config.
// R7 - Fail-output-active status flag set on every failure activation except the R12 case; not set by the test bit.
// R8 - Test bit forces fail pins on; clearing it releases without trigger.
// R9 - Release needs no failure condition and the status flag cleared.
// R10 - Software clears watchdog fail by trigger, then clears status flag.
// R11 - Watchdog fail flag also cleared on sleep, fail-safe entry with a non-watchdog failure, stop disable.
// R12 - Config 2 first watchdog failure does not set the status flag.
// R13 - All pins switch together; first static, second blinks 1.25 Hz.
// R14 - Third pin gives 100 Hz PWM, default 20 percent duty.
// R15 - Duty select chooses 20, 10, 5 or 2.5 percent, reset 20.
// R16 - Alt pins reset as fail pins; config picks off, wake, LS or HS.
// R17 - Wake-configured pin records wake events in second wake status.
// R18 - Pin levels shown in level status in normal and stop modes.
// R19 - Per-mode wake, switch and off behaviour of alternate pins.
// R20 - Switch pin resumes its function after restart, config unchanged.
// R21 - Failure-activated fail pins stay on through restart into normal.
// R22 - Blink and PWM come from oscillator counters, duty from select.
`include "fail_output_defines.svh"
`default_nettype none

module fail_output_and_alt_gpio #(
   parameter int unsigned BLINK_HALF_CYC = `BLINK_HALF_CYC,
   parameter int unsigned PWM_PERIOD_CYC = `PWM_PERIOD_CYC
) (
   input wire logic sys_clk_i,                      // System clock
   input wire logic reset_n_i,                      // Sync reset, low
   input wire fail_output_pkg::sbc_mode_e mode_i,   // Current chip mode
   input wire fail_output_pkg::hw_cfg_e hw_config_i, // Hardware config
   input wire logic thermal_shutdown_stage_two_i,   // Thermal stage two
   input wire logic main_supply_rail_short_i,       // Supply short to gnd
   input wire logic main_supply_rail_ov_i,          // Supply overvoltage
   input wire logic overvoltage_fail_enable_i,      // Overvoltage fails
   input wire logic main_supply_rail_uv_event_i,    // Undervoltage pulse
   input wire logic main_supply_rail_uv_recover_i,  // Chain broken pulse
   input wire logic watchdog_fail_flag_event_i,                // Watchdog fail pulse
   input wire logic wd_trigger_ok_i,                // Good trigger pulse
   input wire logic wd_off_in_stop_i,               // Watchdog disabled
   input wire logic watchdog_fail_flag_safe_en_i,              // Wd goes fail-safe
   input wire logic fail_output_test_bit_i,         // Test activation
   input wire logic fail_flag_clear_i,              // Clear status pulse
   input wire logic [`DUTY_SEL_W-1:0] pulse_duty_select_i, // PWM duty
   input wire fail_output_pkg::alt_cfg_e second_alt_cfg_i, // Pin 2 cfg
   input wire fail_output_pkg::alt_cfg_e pulsed_alt_cfg_i, // Pin 3 cfg
   input wire logic second_alt_sw_on_i,             // Pin 2 switch on
   input wire logic pulsed_alt_sw_on_i,             // Pin 3 switch on
   input wire logic [`ALT_PIN_COUNT-1:0] wake_status_clear_i, // Clear
   input wire logic static_fail_out_i,              // Pin 1 level
   output logic static_fail_out_o,                  // Pin 1 drive value
   output logic static_fail_out_oe_o,               // Pin 1 pull low
   input wire logic second_alt_pin_i,               // Pin 2 level
   output logic second_alt_pin_o,                   // Pin 2 drive value
   output logic second_alt_pin_oe_o,                // Pin 2 driving
   input wire logic pulsed_fail_or_test_pin_i,      // Pin 3 level
   output logic pulsed_fail_or_test_pin_o,          // Pin 3 drive value
   output logic pulsed_fail_or_test_pin_oe_o,       // Pin 3 driving
   output logic fail_output_active_o,               // Status flag
   output logic watchdog_fail_flag_o,               // Watchdog fail flag
   output logic fail_outputs_on_o,                  // Fail pins active
   output logic fail_safe_enter_o,                  // Fail-safe request
   output logic [`ALT_PIN_COUNT-1:0] wake_status_second_o, // Wake bits
   output logic [`ALT_PIN_COUNT-1:0] pin_level_status_o    // Pin levels
);

   // ----
   // Declarations
   // ----
   fail_output_pkg::sbc_mode_e mode_prev_ff;
   logic [`UV_CNT_W-1:0] uv_cnt_ff;
   logic [`WD_CNT_W-1:0] wd_cnt_ff;
   logic wd_flag_ff;
   logic fail_flag_ff;
   logic fo_latch_ff;
   logic nonwd_prev_ff;
   logic fail_safe_ff;
   logic static_oe_ff;
   logic nxt_fo_latch;
   logic sleep_entry;
   logic fs_entry;
   logic uv_fail;
   logic nonwd_fail;
   logic cfg12;
   logic wd_trip;
   logic wd_first_cfg2;
   logic fail_drive;
   logic blink_low;
   logic pwm_low;
   logic in_normal;
   logic lvl_mode;
   logic sw_mode;
   logic pin_in_w [`ALT_PIN_COUNT];
   logic sw_req_w [`ALT_PIN_COUNT];
   logic wave_w [`ALT_PIN_COUNT];
   fail_output_pkg::alt_cfg_e cfg_in_w [`ALT_PIN_COUNT];
   logic pin_out_ff [`ALT_PIN_COUNT];
   logic pin_oe_ff [`ALT_PIN_COUNT];

   // ----
   // Mode decode
   // ----
   assign in_normal = (mode_i == fail_output_pkg::MODE_NORMAL);
   assign lvl_mode = in_normal || (mode_i == fail_output_pkg::MODE_STOP);
   assign sw_mode = lvl_mode || (mode_i == fail_output_pkg::MODE_SLEEP);
   assign sleep_entry = (mode_i == fail_output_pkg::MODE_SLEEP) &&
                        (mode_prev_ff != fail_output_pkg::MODE_SLEEP);
   assign fs_entry = (mode_i == fail_output_pkg::MODE_FAIL_SAFE) &&
                     (mode_prev_ff != fail_output_pkg::MODE_FAIL_SAFE);

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         mode_prev_ff <= fail_output_pkg::MODE_NORMAL;
      end else begin
         mode_prev_ff <= mode_i;
      end
   end

   // ----
   // Non-watchdog failure conditions
   // ----
   assign uv_fail = (uv_cnt_ff == `UV_FAIL_COUNT); // see R5
   assign nonwd_fail = thermal_shutdown_stage_two_i || // see R2
                       main_supply_rail_short_i ||
                       (main_supply_rail_ov_i &&
                        overvoltage_fail_enable_i) || // see R4
                       uv_fail;

   // Undervoltage chain counter; a new event beats a recovery
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         uv_cnt_ff <= '0;
      end else if (main_supply_rail_uv_event_i) begin
         if (uv_cnt_ff != `UV_FAIL_COUNT) begin
            uv_cnt_ff <= uv_cnt_ff + 1'b1; // see R5
         end
      end else if (main_supply_rail_uv_recover_i) begin
         uv_cnt_ff <= '0;
      end
   end

   // ----
   // Watchdog failure handling
   // ----
   assign cfg12 = (hw_config_i == fail_output_pkg::HW_CFG1) ||
                  (hw_config_i == fail_output_pkg::HW_CFG2);
   assign wd_trip = watchdog_fail_flag_event_i &&
                    (cfg12 || (wd_cnt_ff != '0)); // see R3
   assign wd_first_cfg2 = watchdog_fail_flag_event_i && (wd_cnt_ff == '0) &&
                          (hw_config_i == fail_output_pkg::HW_CFG2);

   // Failures since the last good trigger
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         wd_cnt_ff <= '0;
      end else if (watchdog_fail_flag_event_i) begin
         if (wd_cnt_ff != `WD_CNT_MAX) begin
            wd_cnt_ff <= wd_cnt_ff + 1'b1; // see R3
         end
      end else if (wd_trigger_ok_i) begin
         wd_cnt_ff <= '0;
      end
   end

   // A new failure wins over every clear source
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         wd_flag_ff <= 1'b0;
      end else if (watchdog_fail_flag_event_i) begin
         wd_flag_ff <= 1'b1;
      end else if (wd_trigger_ok_i || sleep_entry || // see R10
                   (fs_entry && nonwd_fail) || // see R11
                   ((mode_i == fail_output_pkg::MODE_STOP) &&
                    wd_off_in_stop_i)) begin
         wd_flag_ff <= 1'b0;
      end
   end

   // ----
   // Status flag and fail output latch
   // ----
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         fail_flag_ff <= 1'b0;
      end else if (nonwd_fail || (wd_trip && !wd_first_cfg2)) begin
         fail_flag_ff <= 1'b1; // see R7, see R12
      end else if (fail_flag_clear_i) begin
         fail_flag_ff <= 1'b0; // see R9
      end
   end

   // Held through every mode until properly released
   always_comb begin
      nxt_fo_latch = fo_latch_ff;
      if (nonwd_fail || wd_trip) begin
         nxt_fo_latch = 1'b1; // see R2, see R3
      end else if (!fail_flag_ff && !wd_flag_ff) begin
         nxt_fo_latch = 1'b0; // see R9, see R21
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         fo_latch_ff <= 1'b0;
      end else begin
         fo_latch_ff <= nxt_fo_latch;
      end
   end

   assign fail_drive = fo_latch_ff || fail_output_test_bit_i; // see R8

   // ----
   // Fail-safe request
   // ----
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         nonwd_prev_ff <= 1'b0;
         fail_safe_ff <= 1'b0;
      end else begin
         nonwd_prev_ff <= nonwd_fail;
         fail_safe_ff <= (nonwd_fail && !nonwd_prev_ff) || // see R6
                         (wd_trip && watchdog_fail_flag_safe_en_i);
      end
   end

   // ----
   // Waveforms
   // ----
   fail_wave_gen #(
      .BLINK_HALF(BLINK_HALF_CYC),
      .PWM_PERIOD(PWM_PERIOD_CYC)
   ) u_wave (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .run_i(fail_drive),
      .duty_sel_i(pulse_duty_select_i),
      .blink_low_o(blink_low),
      .pwm_low_o(pwm_low)
   );

   // Static pin pulls low whenever the fail logic is on
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         static_oe_ff <= 1'b0;
      end else begin
         static_oe_ff <= fail_drive; // see R1, see R13
      end
   end

   // ----
   // Alternate function pins
   // ----
   assign pin_in_w[0] = second_alt_pin_i;
   assign pin_in_w[1] = pulsed_fail_or_test_pin_i;
   assign sw_req_w[0] = second_alt_sw_on_i;
   assign sw_req_w[1] = pulsed_alt_sw_on_i;
   assign cfg_in_w[0] = second_alt_cfg_i;
   assign cfg_in_w[1] = pulsed_alt_cfg_i;
   assign wave_w[0] = blink_low;
   assign wave_w[1] = pwm_low;

   for (genvar i = 0; i < `ALT_PIN_COUNT; i++) begin : g_alt
      fail_output_pkg::alt_cfg_e cfg_ff;
      logic sw_ff;
      logic lvl_prev_ff;
      logic lvl_ff;
      logic wake_ff;
      logic wake_cap;
      logic sw_on;
      logic fail_output_test_bit;
      logic is_sw;

      // Config and switch state only follow software in normal mode
      always_ff @(posedge sys_clk_i) begin
         if (!reset_n_i) begin
            cfg_ff <= fail_output_pkg::ALT_FAIL_OUT; // see R16
            sw_ff <= 1'b0;
         end else if (in_normal) begin
            cfg_ff <= cfg_in_w[i]; // see R16
            sw_ff <= sw_req_w[i]; // see R19
         end
      end

      assign is_sw = (cfg_ff == fail_output_pkg::ALT_LOW_SIDE) ||
                     (cfg_ff == fail_output_pkg::ALT_HIGH_SIDE);
      assign wake_cap = (cfg_ff == fail_output_pkg::ALT_WAKE) &&
                        (mode_i != fail_output_pkg::MODE_FAIL_SAFE); // see R19
      assign sw_on = is_sw && sw_mode && sw_ff; // see R19, see R20
      assign fail_output_test_bit = (cfg_ff == fail_output_pkg::ALT_FAIL_OUT) &&
                     fail_drive && wave_w[i]; // see R13, see R14

      always_ff @(posedge sys_clk_i) begin
         if (!reset_n_i) begin
            pin_oe_ff[i] <= 1'b0;
            pin_out_ff[i] <= 1'b0;
         end else begin
            pin_oe_ff[i] <= fail_output_test_bit || sw_on;
            pin_out_ff[i] <= (cfg_ff == fail_output_pkg::ALT_HIGH_SIDE);
         end
      end

      // Level status and wake detection on any pin edge
      always_ff @(posedge sys_clk_i) begin
         if (!reset_n_i) begin
            lvl_prev_ff <= 1'b1;
            lvl_ff <= 1'b0;
         end else begin
            lvl_prev_ff <= pin_in_w[i];
            if (lvl_mode) begin
               lvl_ff <= pin_in_w[i]; // see R18
            end
         end
      end

      always_ff @(posedge sys_clk_i) begin
         if (!reset_n_i) begin
            wake_ff <= 1'b0;
         end else if (wake_cap && (pin_in_w[i] != lvl_prev_ff)) begin
            wake_ff <= 1'b1; // see R17
         end else if (wake_status_clear_i[i]) begin
            wake_ff <= 1'b0;
         end
      end

      assign wake_status_second_o[i] = wake_ff;
      assign pin_level_status_o[i] = lvl_ff;
   end

   // ----
   // Outputs
   // ----
   assign static_fail_out_o = 1'b0;
   assign static_fail_out_oe_o = static_oe_ff;
   assign second_alt_pin_o = pin_out_ff[0];
   assign second_alt_pin_oe_o = pin_oe_ff[0];
   assign pulsed_fail_or_test_pin_o = pin_out_ff[1];
   assign pulsed_fail_or_test_pin_oe_o = pin_oe_ff[1];
   assign fail_output_active_o = fail_flag_ff;
   assign watchdog_fail_flag_o = wd_flag_ff;
   assign fail_outputs_on_o = static_oe_ff;
   assign fail_safe_enter_o = fail_safe_ff;

endmodule : fail_output_and_alt_gpio

`default_nettype wire

// ### rtl/fail_output_defines.svh
// Purpose: Timing counts, widths and codes for the fail output block
// Assumes: 10 MHz system clock
// Notes:   Definitions only
`ifndef FAIL_OUTPUT_DEFINES_SVH
`define FAIL_OUTPUT_DEFINES_SVH

// ----
// Clock and waveform timing
// ----
`define CLK_FREQ_HZ 10000000
// Blink period of 1.25 Hz in milliseconds
`define BLINK_PERIOD_MS 800
`define BLINK_HALF_CYC ((`CLK_FREQ_HZ / 1000) * `BLINK_PERIOD_MS / 2)
// PWM period of 100 Hz in microseconds
`define PWM_PERIOD_US 10000
`define PWM_PERIOD_CYC ((`CLK_FREQ_HZ / 1000000) * `PWM_PERIOD_US)
`define BLINK_CNT_W 23
`define PWM_CNT_W 17

// ----
// Duty select codes and period divisors
// ----
`define DUTY_SEL_W 2
`define DUTY_SEL_20 2'h0
`define DUTY_SEL_10 2'h1
`define DUTY_SEL_5 2'h2
`define DUTY_SEL_2P5 2'h3
`define DUTY_DIV_20 5
`define DUTY_DIV_10 10
`define DUTY_DIV_5 20
`define DUTY_DIV_2P5 40

// ----
// Failure counting
// ----
`define UV_CNT_W 3
`define UV_FAIL_COUNT 3'h4
`define WD_CNT_W 2
`define WD_CNT_MAX 2'h2
`define ALT_PIN_COUNT 2

`endif

// ### rtl/fail_output_pkg.sv
// Purpose: Types shared by the fail output block
// Assumes: Nothing
// Notes:   Mode codes are one-hot
`default_nettype none

package fail_output_pkg;

   typedef enum logic [4:0] {
      MODE_NORMAL    = 5'h01,
      MODE_STOP      = 5'h02,
      MODE_SLEEP     = 5'h04,
      MODE_RESTART   = 5'h08,
      MODE_FAIL_SAFE = 5'h10
   } sbc_mode_e;

   typedef enum logic [2:0] {
      ALT_FAIL_OUT   = 3'h0,
      ALT_OFF        = 3'h1,
      ALT_WAKE       = 3'h2,
      ALT_LOW_SIDE   = 3'h3,
      ALT_HIGH_SIDE  = 3'h4
   } alt_cfg_e;

   typedef enum logic [1:0] {
      HW_CFG1 = 2'h0,
      HW_CFG2 = 2'h1,
      HW_CFG3 = 2'h2,
      HW_CFG4 = 2'h3
   } hw_cfg_e;

endpackage : fail_output_pkg

`default_nettype wire

// ### rtl/fail_wave_gen.sv
// Purpose: Blink and PWM waveform counters for the fail outputs
// Assumes: Counters start in the active phase when run rises
// Notes:   Outputs are 1 while the pin should be pulled low
`include "fail_output_defines.svh"
`default_nettype none

module fail_wave_gen #(
   parameter int unsigned BLINK_HALF = `BLINK_HALF_CYC,
   parameter int unsigned PWM_PERIOD = `PWM_PERIOD_CYC
) (
   input wire logic sys_clk_i,                     // System clock
   input wire logic reset_n_i,                     // Sync reset, low
   input wire logic run_i,                         // Waveforms running
   input wire logic [`DUTY_SEL_W-1:0] duty_sel_i,  // PWM duty code
   output logic blink_low_o,                       // Blink phase low
   output logic pwm_low_o                          // PWM phase low
);

   localparam logic [`BLINK_CNT_W-1:0] BLINK_LAST =
      `BLINK_CNT_W'(BLINK_HALF - 1);
   localparam logic [`PWM_CNT_W-1:0] PWM_LAST = `PWM_CNT_W'(PWM_PERIOD - 1);

   logic [`BLINK_CNT_W-1:0] blink_cnt_ff;
   logic blink_phase_ff;
   logic [`PWM_CNT_W-1:0] pwm_cnt_ff;
   logic [`PWM_CNT_W-1:0] duty_cmp;

   // ----
   // Blink: toggle every half period
   // ----
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i || !run_i) begin
         blink_cnt_ff <= '0;
         blink_phase_ff <= 1'b1;
      end else if (blink_cnt_ff == BLINK_LAST) begin // see R22
         blink_cnt_ff <= '0;
         blink_phase_ff <= ~blink_phase_ff; // see R13
      end else begin
         blink_cnt_ff <= blink_cnt_ff + 1'b1;
      end
   end

   // ----
   // PWM: compare against duty fraction of the period
   // ----
   always_comb begin
      case (duty_sel_i) // see R15
         `DUTY_SEL_20: duty_cmp = `PWM_CNT_W'(PWM_PERIOD / `DUTY_DIV_20);
         `DUTY_SEL_10: duty_cmp = `PWM_CNT_W'(PWM_PERIOD / `DUTY_DIV_10);
         `DUTY_SEL_5: duty_cmp = `PWM_CNT_W'(PWM_PERIOD / `DUTY_DIV_5);
         `DUTY_SEL_2P5: duty_cmp = `PWM_CNT_W'(PWM_PERIOD / `DUTY_DIV_2P5);
         default: duty_cmp = `PWM_CNT_W'(PWM_PERIOD / `DUTY_DIV_20);
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i || !run_i) begin
         pwm_cnt_ff <= '0;
      end else if (pwm_cnt_ff == PWM_LAST) begin // see R22
         pwm_cnt_ff <= '0;
      end else begin
         pwm_cnt_ff <= pwm_cnt_ff + 1'b1;
      end
   end

   assign blink_low_o = blink_phase_ff;
   assign pwm_low_o = (pwm_cnt_ff < duty_cmp); // see R14

endmodule : fail_wave_gen

`default_nettype wire

// ### verif/fail_lamp_model.sv
// Purpose: External lamps with pull-ups on the three fail pins
// Assumes: Pins idle high through the lamp pull-ups
// Notes:   ext2_low_i is a contact pulling pin 2 low when undriven
`default_nettype none
module fail_lamp_model (
   input wire logic oe1_i, // Pin 1 pull low
   input wire logic o2_i, // Pin 2 value
   input wire logic oe2_i, // Pin 2 driving
   input wire logic o3_i, // Pin 3 value
   input wire logic oe3_i, // Pin 3 driving
   input wire logic ext2_low_i, // Contact on pin 2
   output logic lvl1_o, // Pin 1 level
   output logic lvl2_o, // Pin 2 level
   output logic lvl3_o // Pin 3 level
);
   timeunit 1ns;
   timeprecision 1ns;
   assign lvl1_o = !oe1_i;
   assign lvl2_o = oe2_i ? o2_i : !ext2_low_i;
   assign lvl3_o = oe3_i ? o3_i : 1'h1;
endmodule : fail_lamp_model
`default_nettype wire

// ### verif/fail_output_and_alt_gpio_assertions.sv
// Purpose: Port checks for the fail output block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every instance of the block
`default_nettype none
module fail_output_and_alt_gpio_assertions (
   input wire logic sys_clk_i, // Clock
   input wire logic reset_n_i, // Reset
   input wire logic thermal_shutdown_stage_two_i, // Thermal
   input wire logic main_supply_rail_short_i, // Short
   input wire logic main_supply_rail_ov_i, // Overvoltage
   input wire logic overvoltage_fail_enable_i, // Ov enable
   input wire logic watchdog_fail_flag_event_i, // Watchdog fail pulse
   input wire logic wd_trigger_ok_i, // Good trigger
   input wire logic fail_output_test_bit_i, // Test
   input wire logic fail_flag_clear_i, // Flag clear
   input wire logic static_fail_out_o, // Pin 1 value
   input wire logic static_fail_out_oe_o, // Pin 1 oe
   input wire logic fail_outputs_on_o, // Fail on
   input wire logic fail_output_active_o, // Flag
   input wire logic watchdog_fail_flag_o, // Wd flag
   input wire logic fail_safe_enter_o // Fail-safe
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   a_short_flag: assert property (
      main_supply_rail_short_i |=> fail_output_active_o)
      else $error("short left flag clear");
   a_ov_enabled: assert property (
      main_supply_rail_ov_i && overvoltage_fail_enable_i
      |-> ##2 fail_outputs_on_o)
      else $error("enabled overvoltage left outputs off");
   a_test_forces: assert property (
      fail_output_test_bit_i |=> fail_outputs_on_o)
      else $error("test bit left outputs off");
   a_pin1_static: assert property (
      static_fail_out_oe_o == fail_outputs_on_o && !static_fail_out_o)
      else $error("pin 1 not following fail state");
   a_new_fail_safe: assert property (
      $rose(thermal_shutdown_stage_two_i) && !fail_outputs_on_o
      |=> fail_safe_enter_o) else $error("no fail-safe request");
   a_flag_latched: assert property (
      fail_output_active_o && !fail_flag_clear_i |=> fail_output_active_o)
      else $error("flag dropped without clear");
   a_flag_holds_on: assert property (
      fail_output_active_o |=> fail_outputs_on_o)
      else $error("outputs off while flag set");
   a_wd_trig_clear: assert property (
      wd_trigger_ok_i && !watchdog_fail_flag_event_i |=> !watchdog_fail_flag_o)
      else $error("good trigger left wd flag set");
endmodule : fail_output_and_alt_gpio_assertions
bind fail_output_and_alt_gpio fail_output_and_alt_gpio_assertions u_chk (.*);
`default_nettype wire

// ### verif/fail_output_and_alt_gpio_tb.sv
// Purpose: Self-checking bench for the fail output block
// Assumes: Short waveform counts, blink half 8 and PWM period 80
// Notes:   Table rows for plain causes, hand tests after
`default_nettype none
module fail_output_and_alt_gpio_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PP = 80;
   logic sys_clk_i = 1'h0;
   logic reset_n_i = 1'h0;
   fail_output_pkg::sbc_mode_e mode_i;
   fail_output_pkg::hw_cfg_e hw_config_i;
   fail_output_pkg::alt_cfg_e second_alt_cfg_i, pulsed_alt_cfg_i;
   logic thermal_shutdown_stage_two_i, main_supply_rail_short_i;
   logic main_supply_rail_ov_i, overvoltage_fail_enable_i;
   logic main_supply_rail_uv_event_i, main_supply_rail_uv_recover_i;
   logic watchdog_fail_flag_event_i, wd_trigger_ok_i, wd_off_in_stop_i;
   logic watchdog_fail_flag_safe_en_i, fail_output_test_bit_i, fail_flag_clear_i;
   logic second_alt_sw_on_i, pulsed_alt_sw_on_i, ext2_low;
   logic [1:0] pulse_duty_select_i, wake_status_clear_i;
   logic static_fail_out_i, second_alt_pin_i, pulsed_fail_or_test_pin_i;
   logic static_fail_out_o, static_fail_out_oe_o, second_alt_pin_o;
   logic second_alt_pin_oe_o, pulsed_fail_or_test_pin_o;
   logic pulsed_fail_or_test_pin_oe_o, fail_output_active_o;
   logic watchdog_fail_flag_o, fail_outputs_on_o, fail_safe_enter_o;
   logic [1:0] wake_status_second_o, pin_level_status_o;
   int errors = 0;
   int n_checks = 0;
   // Causes {thermal, short, ov, ov enable, test} and expected on
   logic [5:0] rows [6] = '{6'h21, 6'h11, 6'h0D, 6'h08, 6'h04, 6'h03};
   always #50 sys_clk_i = !sys_clk_i;
   fail_output_and_alt_gpio #(.BLINK_HALF_CYC(8), .PWM_PERIOD_CYC(PP))
      u_fail_output_and_alt_gpio (.*);
   fail_lamp_model u_fail_lamp_model (.oe1_i(static_fail_out_oe_o),
      .o2_i(second_alt_pin_o), .oe2_i(second_alt_pin_oe_o),
      .o3_i(pulsed_fail_or_test_pin_o), .oe3_i(pulsed_fail_or_test_pin_oe_o),
      .ext2_low_i(ext2_low), .lvl1_o(static_fail_out_i),
      .lvl2_o(second_alt_pin_i), .lvl3_o(pulsed_fail_or_test_pin_i));
   // ----
   // Shared tasks
   // ----
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask : cyc
   task automatic pulse(ref logic s);
      s = 1'h1;
      cyc(1);
      s = 1'h0;
      cyc(1);
   endtask : pulse
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (8000) @(posedge sys_clk_i);
      errors++;
      summarize();
   end
   initial begin
      int n, b;
      mode_i = fail_output_pkg::MODE_NORMAL;
      hw_config_i = fail_output_pkg::HW_CFG1;
      second_alt_cfg_i = fail_output_pkg::ALT_FAIL_OUT;
      pulsed_alt_cfg_i = fail_output_pkg::ALT_FAIL_OUT;
      {thermal_shutdown_stage_two_i, main_supply_rail_short_i,
         main_supply_rail_ov_i, overvoltage_fail_enable_i,
         main_supply_rail_uv_event_i, main_supply_rail_uv_recover_i,
         watchdog_fail_flag_event_i, wd_trigger_ok_i, wd_off_in_stop_i, ext2_low,
         watchdog_fail_flag_safe_en_i, fail_output_test_bit_i, fail_flag_clear_i,
         second_alt_sw_on_i, pulsed_alt_sw_on_i, pulse_duty_select_i,
         wake_status_clear_i} = '0;
      cyc(16);
      reset_n_i = 1'h1;
      chk({static_fail_out_oe_o, second_alt_pin_oe_o, fail_outputs_on_o,
         pulsed_fail_or_test_pin_oe_o, fail_output_active_o}, 8'h00);
      foreach (rows[i]) begin
         {thermal_shutdown_stage_two_i, main_supply_rail_short_i,
            main_supply_rail_ov_i, overvoltage_fail_enable_i,
            fail_output_test_bit_i} = rows[i][5:1];
         cyc(1);
         chk(fail_safe_enter_o, rows[i][0] & !rows[i][1]);
         cyc(1);
         chk(fail_outputs_on_o, rows[i][0]);
         chk(fail_output_active_o, rows[i][0] & !rows[i][1]);
         chk(static_fail_out_i, !rows[i][0]);
         {thermal_shutdown_stage_two_i, main_supply_rail_short_i,
            main_supply_rail_ov_i, fail_output_test_bit_i} = '0;
         cyc(3);
         chk(fail_outputs_on_o, rows[i][0] & !rows[i][1]);
         pulse(fail_flag_clear_i);
         cyc(3);
         chk(fail_outputs_on_o, 8'h00);
         $display("cause row %0d done", i);
      end
      repeat (3) pulse(main_supply_rail_uv_event_i);
      chk(fail_outputs_on_o, 8'h00);
      pulse(main_supply_rail_uv_event_i);
      cyc(1);
      chk(fail_outputs_on_o, 8'h01);
      pulse(main_supply_rail_uv_recover_i);
      pulse(fail_flag_clear_i);
      cyc(3);
      chk(fail_outputs_on_o, 8'h00);
      $display("undervoltage done");
      for (int k = 0; k < 4; k++) begin
         hw_config_i = fail_output_pkg::hw_cfg_e'(k);
         pulse(watchdog_fail_flag_event_i);
         chk(fail_outputs_on_o, 8'(k < 2));
         chk(fail_output_active_o, 8'(k == 0));
         if (k > 1) begin
            pulse(watchdog_fail_flag_event_i);
            chk(fail_outputs_on_o, 8'h01);
         end
         pulse(wd_trigger_ok_i);
         chk(watchdog_fail_flag_o, 8'h00);
         pulse(fail_flag_clear_i);
         cyc(3);
         chk(fail_outputs_on_o, 8'h00);
      end
      pulse(watchdog_fail_flag_event_i);
      chk(watchdog_fail_flag_o, 8'h01);
      mode_i = fail_output_pkg::MODE_SLEEP;
      cyc(2);
      chk(watchdog_fail_flag_o, 8'h00);
      mode_i = fail_output_pkg::MODE_NORMAL;
      $display("watchdog done");
      fail_output_test_bit_i = 1'h1;
      for (int d = 0; d < 4; d++) begin
         pulse_duty_select_i = 2'(d);
         cyc(PP);
         n = 0;
         b = 0;
         repeat (PP) begin
            cyc(1);
            n += int'(!pulsed_fail_or_test_pin_i);
            b += int'(!second_alt_pin_i);
         end
         chk(8'(n), 8'(PP / (5 << d)));
         chk(8'(b), 8'(PP / 2));
      end
      $display("waveforms done");
      fail_output_test_bit_i = 1'h0;
      cyc(3);
      second_alt_cfg_i = fail_output_pkg::ALT_WAKE;
      pulsed_alt_cfg_i = fail_output_pkg::ALT_HIGH_SIDE;
      pulsed_alt_sw_on_i = 1'h1;
      cyc(3);
      chk({wake_status_second_o, pulsed_fail_or_test_pin_i}, 8'h01);
      ext2_low = 1'h1;
      cyc(3);
      chk(wake_status_second_o, 8'h01);
      chk(pin_level_status_o, 8'h02);
      mode_i = fail_output_pkg::MODE_RESTART;
      cyc(3);
      chk(pulsed_fail_or_test_pin_oe_o, 8'h00);
      mode_i = fail_output_pkg::MODE_NORMAL;
      cyc(3);
      chk(pulsed_fail_or_test_pin_oe_o, 8'h01);
      $display("alternate pins done");
      summarize();
   end
endmodule : fail_output_and_alt_gpio_tb
`default_nettype wire
